// ---- design/pir_pkg.sv ----
/*
 * constants for the dual-function interrupt router: register offsets,
 * field positions, reset values and write masks.
 * assumes byte offsets within the local configuration space.
 */
package pir_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0]  ADDR_MIC       = 8'h04;
    localparam logic [7:0]  ADDR_GIS       = 8'h10;

    // ---------------------------------------------------------------
    // global status/control field positions
    // ---------------------------------------------------------------
    localparam int          GIS_U0_MSK     = 16;
    localparam int          GIS_U1_MSK     = 17;
    localparam int          GIS_MIO_MSK    = 18;
    localparam int          GIS_MIO_PD_MSK = 20;
    localparam int          GIS_F0_PD_MSK  = 24;
    localparam int          GIS_F1_PD_MSK  = 25;
    localparam int          GIS_MIO_SEL    = 26;
    localparam int          GIS_PAR_EN     = 29;

    localparam logic [31:0] GIS_RST        = 32'h2c03_0000;
    localparam logic [31:0] GIS_WMASK      = 32'h2f3f_0000;

    // ---------------------------------------------------------------
    // multipurpose pin configuration fields
    // ---------------------------------------------------------------
    localparam int          MIC_INV        = 0;
    localparam int          MIC_PME_EN     = 4;
    localparam logic [31:0] MIC_RST        = 32'h0000_0000;
    localparam logic [31:0] MIC_WMASK      = 32'h0000_003f;

    // ---------------------------------------------------------------
    // interrupt pin field and serial-memory load targets
    // ---------------------------------------------------------------
    localparam logic [7:0]  PIN_NONE       = 8'h00;
    localparam logic [7:0]  PIN_A          = 8'h01;
    localparam logic [7:0]  PIN_B          = 8'h02;
    localparam logic [7:0]  PIN_RST        = 8'h01;

    typedef enum logic [1:0] {
        EE_MIC  = 2'b00,
        EE_GIS  = 2'b01,
        EE_PIN0 = 2'b10,
        EE_PIN1 = 2'b11
    } pir_ee_sel_t;

endpackage : pir_pkg

// ---- design/pir_pin_route.sv ----
/*
 * decodes one function's interrupt pin field onto the two shared pins.
 * assumes the field is held stable by its owner.
 */
`timescale 1ns/1ps

module pir_pin_route (
    input  wire logic       req,
    input  wire logic [7:0] pin_field,
    output logic            to_a,
    output logic            to_b
);

    // reserved and zero values reach neither pin
    assign to_a = req && (pin_field == pir_pkg::PIN_A);
    assign to_b = req && (pin_field == pir_pkg::PIN_B);

endmodule : pir_pin_route

// ---- design/pir_mio_cond.sv ----
/*
 * conditions one multipurpose pin: sense inversion, masking and
 * steering to function 0 or 1.
 * assumes the pin is synchronous to the system clock.
 */
`timescale 1ns/1ps

module pir_mio_cond (
    input  wire logic       pin,
    input  wire logic       inv,
    input  wire logic       sel_f1,
    input  wire logic       irq_msk,
    input  wire logic       pd_msk,
    input  wire logic       pme_en,
    output logic            state,
    output logic [1:0]      irq_f,
    output logic            pd_f0,
    output logic            pd_f1,
    output logic [1:0]      pme_f
);

    logic                   irq_on;

    assign state  = pin ^ inv;
    assign irq_on = state && irq_msk;
    assign irq_f  = {irq_on && sel_f1, irq_on && !sel_f1};
    // function 0 sees the idle state as its powerdown state
    assign pd_f0  = !state && pd_msk && !sel_f1;
    assign pd_f1  = state && pd_msk && sel_f1;
    assign pme_f  = {state && pme_en && sel_f1, state && pme_en && !sel_f1};

endmodule : pir_mio_cond

// ---- design/pir_irq_router.sv ----
/*
 * interrupt router for a two-function target: merges the uart,
 * multipurpose pin, parallel port and powerdown sources onto the
 * shared open-drain interrupt pins, and holds the global status/control,
 * pin configuration and interrupt pin field registers.
 * assumes the local register decode and serial-memory loader sit outside,
 * the powerdown filter of function 0 sits outside, and all inputs are
 * synchronous to clk_sys.
 */
`timescale 1ns/1ps

module pir_irq_router (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        ee_wr,
    input  wire logic [1:0]  ee_sel,
    input  wire logic [31:0] ee_data,
    input  wire logic [11:0] uart_irq_source_mirror,
    input  wire logic        par_irq,
    input  wire logic [1:0]  multipurpose_pin,
    input  wire logic        pd_req_f0,
    input  wire logic        pd_req_f1,
    output logic [1:0]       mio_pd_f0,
    output logic [1:0]       pme_req,
    output logic [7:0]       int_pin_f0,
    output logic [7:0]       int_pin_f1,
    input  wire logic        inta_n_i,
    output logic             inta_n_o,
    output logic             inta_n_oe,
    input  wire logic        intb_n_i,
    output logic             intb_n_o,
    output logic             intb_n_oe
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [31:0]             gis_ctl_r;
    logic [31:0]             gis_ctl_nxt;
    logic [31:0]             mic_r;
    logic [31:0]             mic_nxt;
    logic [7:0]              pin0_r;
    logic [7:0]              pin1_r;
    logic [1:0]              pd_st_r;
    logic [1:0]              pd_st_nxt;
    logic                    inta_r;
    logic                    intb_r;
    logic [1:0]              pme_r;
    logic [31:0]             rdata_r;
    logic [31:0]             rdata_nxt;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    logic                    sel_gis;
    logic                    sel_mic;
    logic                    wr_gis;
    logic                    wr_mic;
    logic                    rd_gis;
    logic                    ee_gis;
    logic                    ee_mic;

    assign sel_gis = (reg_addr == pir_pkg::ADDR_GIS);
    assign sel_mic = (reg_addr == pir_pkg::ADDR_MIC);
    assign wr_gis  = reg_wr && sel_gis;
    assign wr_mic  = reg_wr && sel_mic;
    // reads from either function reach the same register
    assign rd_gis  = reg_rd && sel_gis;
    assign ee_gis  = ee_wr && (ee_sel == pir_pkg::EE_GIS);
    assign ee_mic  = ee_wr && (ee_sel == pir_pkg::EE_MIC);

    // ---------------------------------------------------------------
    // sources
    // ---------------------------------------------------------------
    logic [1:0]              uart_irq;
    logic [1:0]              mio_st;
    logic [1:0]              mio_irq_f [2];
    logic [1:0]              mio_pme_f [2];
    logic [1:0]              mio_pd_f1;

    // the mirror reads 1 in bit 0 while no uart interrupt pends, so a
    // uart with its own enables off after reset never requests
    assign uart_irq = ~{uart_irq_source_mirror[6],
                        uart_irq_source_mirror[0]};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_mio
            pir_mio_cond u_mio (
                .pin     (multipurpose_pin[i]),
                .inv     (mic_r[pir_pkg::MIC_INV + i]),
                .sel_f1  (gis_ctl_r[pir_pkg::GIS_MIO_SEL + i]),
                .irq_msk (gis_ctl_r[pir_pkg::GIS_MIO_MSK + i]),
                .pd_msk  (gis_ctl_r[pir_pkg::GIS_MIO_PD_MSK + i]),
                .pme_en  (mic_r[pir_pkg::MIC_PME_EN + i]),
                .state   (mio_st[i]),
                .irq_f   (mio_irq_f[i]),
                .pd_f0   (mio_pd_f0[i]),
                .pd_f1   (mio_pd_f1[i]),
                .pme_f   (mio_pme_f[i])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // function requests
    // ---------------------------------------------------------------
    logic [1:0]              fn_req;
    logic [1:0]              to_a;
    logic [1:0]              to_b;
    logic                    pd_set1;

    assign fn_req[0] = (uart_irq[0] && gis_ctl_r[pir_pkg::GIS_U0_MSK])
                     | (uart_irq[1] && gis_ctl_r[pir_pkg::GIS_U1_MSK])
                     | mio_irq_f[0][0] | mio_irq_f[1][0]
                     | (pd_st_r[0] && gis_ctl_r[pir_pkg::GIS_F0_PD_MSK]);
    assign fn_req[1] = (par_irq && gis_ctl_r[pir_pkg::GIS_PAR_EN])
                     | mio_irq_f[0][1] | mio_irq_f[1][1]
                     | (pd_st_r[1] && gis_ctl_r[pir_pkg::GIS_F1_PD_MSK]);

    generate
        for (genvar f = 0; f < 2; f++) begin : g_fn
            pir_pin_route u_route (
                .req       (fn_req[f]),
                .pin_field (f == 0 ? pin0_r : pin1_r),
                .to_a      (to_a[f]),
                .to_b      (to_b[f])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // next values
    // ---------------------------------------------------------------
    // a pin routed to function 1 requests powerdown at once, no filter
    assign pd_set1   = pd_req_f1 | (|mio_pd_f1);
    // a new request in the reading cycle survives the clear
    assign pd_st_nxt = {pd_set1, pd_req_f0}
                     | (pd_st_r & {2{!rd_gis}});

    assign gis_ctl_nxt = wr_gis ? (reg_wdata & pir_pkg::GIS_WMASK)
                       : ee_gis ? (ee_data & pir_pkg::GIS_WMASK)
                       : gis_ctl_r;
    assign mic_nxt     = wr_mic ? (reg_wdata & pir_pkg::MIC_WMASK)
                       : ee_mic ? (ee_data & pir_pkg::MIC_WMASK)
                       : mic_r;

    assign rdata_nxt = !reg_rd ? rdata_r
                     : sel_gis ? ((gis_ctl_r & pir_pkg::GIS_WMASK)
                                  | {3'h0, par_irq, 4'h0, pd_st_r,
                                     18'h0, mio_st, uart_irq})
                     : sel_mic ? mic_r
                     : 32'h0000_0000;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gis_ctl_r <= pir_pkg::GIS_RST;
            mic_r     <= pir_pkg::MIC_RST;
            pd_st_r   <= 2'h0;
            rdata_r   <= 32'h0000_0000;
        end else begin
            gis_ctl_r <= gis_ctl_nxt;
            mic_r     <= mic_nxt;
            pd_st_r   <= pd_st_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // the pin fields have no path from register writes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin0_r <= pir_pkg::PIN_RST;
            pin1_r <= pir_pkg::PIN_RST;
        end else if (ee_wr && ee_sel == pir_pkg::EE_PIN0) begin
            pin0_r <= ee_data[7:0];
        end else if (ee_wr && ee_sel == pir_pkg::EE_PIN1) begin
            pin1_r <= ee_data[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            inta_r <= 1'b0;
            intb_r <= 1'b0;
            pme_r  <= 2'h0;
        end else begin
            inta_r <= |to_a;
            intb_r <= |to_b;
            pme_r  <= mio_pme_f[0] | mio_pme_f[1];
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // open drain: drive low only while asserting, let others share
    assign inta_n_o   = 1'b0;
    assign inta_n_oe  = inta_r;
    assign intb_n_o   = 1'b0;
    assign intb_n_oe  = intb_r;
    assign reg_rdata  = rdata_r;
    assign int_pin_f0 = pin0_r;
    assign int_pin_f1 = pin1_r;
    assign pme_req    = pme_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    nopin_quiet_a: assert property (
        (pin0_r != pir_pkg::PIN_A && pin1_r != pir_pkg::PIN_A) |=> !inta_n_oe)
        else $error("pin a driven with no function on it");
    uart_gate_a: assert property (
        (uart_irq[0] && gis_ctl_r[pir_pkg::GIS_U0_MSK] && pin0_r == pir_pkg::PIN_A)
        |=> inta_n_oe)
        else $error("enabled uart 0 did not assert pin a");
    par_gate_a: assert property (
        (par_irq && gis_ctl_r[pir_pkg::GIS_PAR_EN] && pin1_r == pir_pkg::PIN_B) |=> intb_n_oe)
        else $error("enabled parallel interrupt missing on pin b");
    par_stat_a: assert property (
        rd_gis |=> reg_rdata[28] == $past(par_irq))
        else $error("parallel status bit wrong");
    uart_stat_a: assert property (
        rd_gis |=> reg_rdata[1:0] == ~{$past(uart_irq_source_mirror[6]),
                                        $past(uart_irq_source_mirror[0])})
        else $error("uart status bits not inverted mirror");
    pd_sticky_a: assert property (
        (pd_st_r[0] && !rd_gis) |=> pd_st_r[0])
        else $error("powerdown status lost without a read");
    pd_clear_a: assert property (
        (rd_gis && !pd_req_f0) |=> !pd_st_r[0])
        else $error("powerdown status not cleared by read");
    pin_ro_a: assert property (
        (!ee_wr) |=> $stable(pin0_r) && $stable(pin1_r))
        else $error("pin field changed without a load");
    mio_route_a: assert property (
        (mio_st[0] && gis_ctl_r[pir_pkg::GIS_MIO_MSK] && gis_ctl_r[pir_pkg::GIS_MIO_SEL]
         && pin1_r == pir_pkg::PIN_B)
        |=> intb_n_oe)
        else $error("steered pin 0 missing on function 1 pin");
    pd_mask_a: assert property (
        (pd_st_r[1] && gis_ctl_r[pir_pkg::GIS_F1_PD_MSK] && pin1_r == pir_pkg::PIN_A)
        |=> inta_n_oe)
        else $error("function 1 powerdown interrupt missing");
    pinb_quiet_a: assert property (
        (pin0_r != pir_pkg::PIN_B && pin1_r != pir_pkg::PIN_B) |=> !intb_n_oe)
        else $error("pin b driven with no function on it");
    uart1_gate_a: assert property (
        (uart_irq[1] && gis_ctl_r[pir_pkg::GIS_U1_MSK] && pin0_r == pir_pkg::PIN_A)
        |=> inta_n_oe)
        else $error("enabled uart 1 did not assert pin a");
    mio_f0_a: assert property (
        (mio_st[1] && gis_ctl_r[pir_pkg::GIS_MIO_MSK + 1]
         && !gis_ctl_r[pir_pkg::GIS_MIO_SEL + 1] && pin0_r == pir_pkg::PIN_A)
        |=> inta_n_oe)
        else $error("pin 1 steered to function 0 missing on pin a");
    pd0_mask_a: assert property (
        (pd_st_r[0] && gis_ctl_r[pir_pkg::GIS_F0_PD_MSK] && pin0_r == pir_pkg::PIN_A)
        |=> inta_n_oe)
        else $error("function 0 powerdown interrupt missing");
    pd_set_a: assert property (
        pd_req_f1 |=> pd_st_r[1])
        else $error("function 1 powerdown request not recorded");
    pd1_sticky_a: assert property (
        (pd_st_r[1] && !rd_gis) |=> pd_st_r[1])
        else $error("function 1 powerdown status lost without a read");
    mio_stat_a: assert property (
        rd_gis |=> reg_rdata[3:2] == $past(multipurpose_pin ^ mic_r[pir_pkg::MIC_INV +: 2]))
        else $error("pin state bits wrong");
    par_block_a: assert property (
        (par_irq && !gis_ctl_r[pir_pkg::GIS_PAR_EN] && !pd_st_r[1]
         && gis_ctl_r[pir_pkg::GIS_MIO_MSK +: 2] == 2'h0
         && pin0_r != pir_pkg::PIN_B && pin1_r == pir_pkg::PIN_B)
        |=> !intb_n_oe)
        else $error("disabled parallel interrupt reached pin b");

    uart_irq_c: cover property (uart_irq[0] ##1 inta_n_oe);
    par_irq_c:  cover property (par_irq && gis_ctl_r[pir_pkg::GIS_PAR_EN] ##1 inta_n_oe);
    pd_read_c:  cover property (pd_st_r[1] ##1 rd_gis ##1 !pd_st_r[1]);
    mio_pd_c:   cover property (mio_pd_f1[0] ##1 pd_st_r[1]);

endmodule : pir_irq_router

// ---- verif/pir_host_model.sv ----
/*
 * host-side view of the two shared interrupt lines seen by the system router.
 * assumes the device pulls a line low only while its enable is high.
 */
`timescale 1ns/1ps

module pir_host_model (
    input  wire logic inta_n_o,
    input  wire logic inta_n_oe,
    input  wire logic intb_n_o,
    input  wire logic intb_n_oe,
    output logic      inta_n,
    output logic      intb_n
);
    // ---------------------------------------------------------------
    // open-drain lines with board pull-ups; a released line reads high
    // ---------------------------------------------------------------
    assign inta_n = inta_n_oe ? inta_n_o : 1'b1;
    assign intb_n = intb_n_oe ? intb_n_o : 1'b1;
endmodule : pir_host_model

// ---- verif/pir_irq_router_tb.sv ----
/*
 * self-checking bench for the interrupt router: reset, then routing table,
 * status, powerdown and wake-up event cases.
 * assumes the router and the host line model are compiled before it.
 */
`timescale 1ns/1ps

module pir_irq_router_tb;
    typedef struct {
        logic [31:0] global_irq_status_control;
        logic [31:0] multipurpose_pin_config;
        logic [7:0]  f0;
        logic [7:0]  f1;
        logic [11:0] mir;
        logic        par;
        logic [1:0]  mio;
        logic        a;
        logic        b;
    } pir_row_t;

    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic        ee_wr = 1'b0;
    logic [1:0]  ee_sel = 2'h0;
    logic [31:0] ee_data = 32'h0000_0000;
    logic [11:0] mir = 12'h041;
    logic        par = 1'b0;
    logic [1:0]  mio = 2'h0;
    logic        pd0 = 1'b0;
    logic        pd1 = 1'b0;
    logic [1:0]  pme_req;
    logic [1:0]  mio_pd_f0;
    logic [7:0]  int_pin_f0;
    logic [7:0]  int_pin_f1;
    logic        ao, aoe, bo, boe, inta_n, intb_n;
    int          failures = 0;
    int          total_checks = 0;
    pir_row_t    rows [14];

    always #4 clk_sys = ~clk_sys;

    pir_irq_router u_pir_irq_router (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ee_wr(ee_wr), .ee_sel(ee_sel), .ee_data(ee_data), .uart_irq_source_mirror(mir),
        .par_irq(par), .multipurpose_pin(mio), .pd_req_f0(pd0), .pd_req_f1(pd1),
        .mio_pd_f0(mio_pd_f0), .pme_req(pme_req),
        .int_pin_f0(int_pin_f0), .int_pin_f1(int_pin_f1),
        .inta_n_i(inta_n), .inta_n_o(ao), .inta_n_oe(aoe),
        .intb_n_i(intb_n), .intb_n_o(bo), .intb_n_oe(boe));

    pir_host_model u_pir_host_model (.inta_n_o(ao), .inta_n_oe(aoe), .intb_n_o(bo),
        .intb_n_oe(boe), .inta_n(inta_n), .intb_n(intb_n));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rst();
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
    endtask : rst

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic ee(input logic [1:0] s, input logic [31:0] d);
        @(posedge clk_sys);
        ee_sel  <= s;
        ee_data <= d;
        ee_wr   <= 1'b1;
        @(posedge clk_sys);
        ee_wr   <= 1'b0;
    endtask : ee

    // read answers exactly one cycle after the strobe edge
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rdchk

    // oe follows a source change one cycle later
    task automatic pins(input logic a, input logic b);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({30'h0, inta_n, intb_n}, {30'h0, ~a, ~b});
    endtask : pins

    task automatic pd(input logic p0, input logic p1);
        @(posedge clk_sys);
        pd0 <= p0;
        pd1 <= p1;
        @(posedge clk_sys);
        pd0 <= 1'b0;
        pd1 <= 1'b0;
    endtask : pd

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial begin
        // ---------------------------------------------------------------
        // routing table: gis, mic, fields, sources, expected a/b lines
        // ---------------------------------------------------------------
        rows = '{
            '{32'h2c03_0000, 0, 8'h01, 8'h01, 12'h040, 1'b0, 2'h0, 1'b1, 1'b0},
            '{32'h2c03_0000, 0, 8'h02, 8'h01, 12'h040, 1'b0, 2'h0, 1'b0, 1'b1},
            '{32'h2c03_0000, 0, 8'h00, 8'h02, 12'h040, 1'b0, 2'h0, 1'b0, 1'b0},
            '{32'h2c03_0000, 0, 8'h03, 8'h01, 12'h040, 1'b0, 2'h0, 1'b0, 1'b0},
            '{32'h2c02_0000, 0, 8'h01, 8'h01, 12'h040, 1'b0, 2'h0, 1'b0, 1'b0},
            '{32'h2c03_0000, 0, 8'h01, 8'h02, 12'h041, 1'b1, 2'h0, 1'b0, 1'b1},
            '{32'h0c03_0000, 0, 8'h01, 8'h02, 12'h041, 1'b1, 2'h0, 1'b0, 1'b0},
            '{32'h2c07_0000, 0, 8'h01, 8'h02, 12'h041, 1'b0, 2'h1, 1'b0, 1'b1},
            '{32'h2807_0000, 0, 8'h01, 8'h02, 12'h041, 1'b0, 2'h1, 1'b1, 1'b0},
            '{32'h2c0b_0000, 0, 8'h01, 8'h02, 12'h041, 1'b0, 2'h2, 1'b0, 1'b1},
            '{32'h240b_0000, 0, 8'h01, 8'h02, 12'h041, 1'b0, 2'h2, 1'b1, 1'b0},
            '{32'h2807_0000, 1, 8'h01, 8'h02, 12'h041, 1'b0, 2'h0, 1'b1, 1'b0},
            '{32'h2803_0000, 0, 8'h01, 8'h02, 12'h041, 1'b0, 2'h1, 1'b0, 1'b0},
            '{32'h2c03_0000, 0, 8'h01, 8'h01, 12'h001, 1'b1, 2'h0, 1'b1, 1'b0}};
        rst();
        chk({24'h0, int_pin_f0}, {24'h0, pir_pkg::PIN_RST});
        chk({24'h0, int_pin_f1}, {24'h0, pir_pkg::PIN_RST});
        rdchk(pir_pkg::ADDR_GIS, pir_pkg::GIS_RST);
        rdchk(pir_pkg::ADDR_MIC, pir_pkg::MIC_RST);
        pins(1'b0, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(pir_pkg::ADDR_GIS, rows[i].global_irq_status_control);
            wr(pir_pkg::ADDR_MIC, rows[i].multipurpose_pin_config);
            ee(pir_pkg::EE_PIN0, {24'h0, rows[i].f0});
            ee(pir_pkg::EE_PIN1, {24'h0, rows[i].f1});
            mir <= rows[i].mir;
            par <= rows[i].par;
            mio <= rows[i].mio;
            pins(rows[i].a, rows[i].b);
        end
        $display("test routing done");
        // ---------------------------------------------------------------
        // status readback, read-only bits, unmapped place
        // ---------------------------------------------------------------
        @(posedge clk_sys);
        mir <= 12'h000;
        mio <= 2'h0;
        wr(pir_pkg::ADDR_GIS, 32'hffff_ffff);
        chk({24'h0, int_pin_f0}, 32'h0000_0001);
        rdchk(pir_pkg::ADDR_GIS, 32'h3f3f_0003);
        wr(pir_pkg::ADDR_GIS, 32'h0c03_0000);
        rdchk(pir_pkg::ADDR_GIS, 32'h1c03_0003);
        rdchk(8'h20, 32'h0000_0000);
        $display("test status done");
        // ---------------------------------------------------------------
        // powerdown sticky bits and their masks
        // ---------------------------------------------------------------
        @(posedge clk_sys);
        mir <= 12'h041;
        par <= 1'b0;
        wr(pir_pkg::ADDR_GIS, 32'h2e03_0000);
        pd(1'b0, 1'b1);
        pins(1'b1, 1'b0);
        rdchk(pir_pkg::ADDR_GIS, 32'h2e83_0000);
        rdchk(pir_pkg::ADDR_GIS, 32'h2e03_0000);
        pins(1'b0, 1'b0);
        wr(pir_pkg::ADDR_GIS, 32'h2d03_0000);
        pd(1'b1, 1'b0);
        pins(1'b1, 1'b0);
        rdchk(pir_pkg::ADDR_GIS, 32'h2d43_0000);
        wr(pir_pkg::ADDR_GIS, 32'h2c03_0000);
        pd(1'b0, 1'b1);
        pins(1'b0, 1'b0);
        rdchk(pir_pkg::ADDR_GIS, 32'h2c83_0000);
        $display("test powerdown done");
        // ---------------------------------------------------------------
        // wake-up steering, serial-memory load, reset in mid-run
        // ---------------------------------------------------------------
        wr(pir_pkg::ADDR_MIC, 32'h0000_0010);
        mio <= 2'h1;
        pins(1'b0, 1'b0);
        chk({30'h0, pme_req}, 32'h0000_0002);
        wr(pir_pkg::ADDR_GIS, 32'h2803_0000);
        pins(1'b0, 1'b0);
        chk({30'h0, pme_req}, 32'h0000_0001);
        // powerdown steering of pin 0: idle state to function 0, active to function 1
        wr(pir_pkg::ADDR_GIS, 32'h2813_0000);
        mio <= 2'h0;
        pins(1'b0, 1'b0);
        chk({30'h0, mio_pd_f0}, 32'h0000_0001);
        wr(pir_pkg::ADDR_GIS, 32'h2e13_0000);
        mio <= 2'h1;
        pins(1'b1, 1'b0);
        chk({30'h0, mio_pd_f0}, 32'h0000_0000);
        @(posedge clk_sys);
        mio <= 2'h0;
        ee(pir_pkg::EE_GIS, 32'h0000_0000);
        rdchk(pir_pkg::ADDR_GIS, 32'h0080_0000);
        rdchk(pir_pkg::ADDR_GIS, 32'h0000_0000);
        ee(pir_pkg::EE_PIN1, 32'h0000_0002);
        rst();
        chk({24'h0, int_pin_f1}, 32'h0000_0001);
        rdchk(pir_pkg::ADDR_GIS, pir_pkg::GIS_RST);
        $display("test reload done");
        report_and_stop();
    end
endmodule : pir_irq_router_tb
